/* hw/irq_summary_top.sv */
`timescale 1ns/1ps
`default_nettype none

module irq_summary_top #(
    parameter int SOURCES = irq_summary_pkg::SOURCES_PER_CHANNEL
) (
    input  wire logic                                            clk,
    input  wire logic                                            rst_n,
    input  wire logic                                            psel,
    input  wire logic                                            penable,
    input  wire logic                                            pwrite,
    input  wire logic [irq_summary_pkg::ADDR_WIDTH-1:0]          paddr,
    input  wire logic [irq_summary_pkg::DATA_WIDTH-1:0]          pwdata,
    input  wire logic [irq_summary_pkg::STROBE_WIDTH-1:0]        pstrb,
    output logic      [irq_summary_pkg::DATA_WIDTH-1:0]          prdata,
    output logic                                                 pready,
    output logic                                                 pslverr,
    input  wire logic [irq_summary_pkg::NUM_CHANNELS*SOURCES-1:0] channel_sources,
    output logic      [irq_summary_pkg::NUM_CHANNELS-1:0]        channel_pending,
    output logic                                                 irq
);

    localparam int NCH = irq_summary_pkg::NUM_CHANNELS;
    localparam int DW  = irq_summary_pkg::DATA_WIDTH;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DW-1:0]  rdata;
        logic           err;
        logic [NCH-1:0] status;
        logic [NCH-1:0] mask;
        logic [NCH-1:0] seen;
    } top_state_t;

    localparam top_state_t RESET_STATE = '{
        rdata:  irq_summary_pkg::RDATA_RESET,
        err:    1'b0,
        status: irq_summary_pkg::STATUS_RESET,
        mask:   irq_summary_pkg::MASK_RESET,
        seen:   irq_summary_pkg::STATUS_RESET
    };

    top_state_t     state;
    top_state_t     next_state;
    logic [NCH-1:0] pending;

    // ------------------------------------------------------------------
    // per-channel aggregation
    // ------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_channel
            channel_aggregate #(
                .SOURCES (SOURCES)
            ) u_aggregate (
                .clk     (clk),
                .rst_n   (rst_n),
                .sources (channel_sources[ch*SOURCES +: SOURCES]),
                .pending (pending[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // summary field packing
    // ------------------------------------------------------------------
    logic [7:0] low_field;
    logic [7:0] mid_field;
    logic [7:0] upper_field;
    logic [7:0] zero_field;

    always_comb begin
        low_field   = pending[irq_summary_pkg::LOW_FIRST_CHANNEL
                              +: irq_summary_pkg::BYTE_FIELD_WIDTH];
        mid_field   = pending[irq_summary_pkg::MID_FIRST_CHANNEL
                              +: irq_summary_pkg::BYTE_FIELD_WIDTH];
        upper_field = irq_summary_pkg::SUMMARY_RESET;
        upper_field[irq_summary_pkg::UPPER_FIELD_WIDTH-1:0] =
            pending[irq_summary_pkg::UPPER_FIRST_CHANNEL
                    +: irq_summary_pkg::UPPER_FIELD_WIDTH];
        zero_field  = irq_summary_pkg::SUMMARY_RESET;
        zero_field[irq_summary_pkg::ZERO_FIELD_BIT] =
            pending[irq_summary_pkg::ZERO_CHANNEL];
    end

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic          mapped;
    logic          hit_status;
    logic          hit_mask;
    logic [DW-1:0] read_value;

    always_comb begin
        mapped     = 1'b1;
        hit_status = 1'b0;
        hit_mask   = 1'b0;
        read_value = irq_summary_pkg::RDATA_RESET;
        case (paddr)
            irq_summary_pkg::OFFSET_LOW_SUMMARY: begin
                read_value[7:0] = low_field;
            end
            irq_summary_pkg::OFFSET_MID_SUMMARY: begin
                read_value[7:0] = mid_field;
            end
            irq_summary_pkg::OFFSET_UPPER_SUMMARY: begin
                read_value[7:0] = upper_field;
            end
            irq_summary_pkg::OFFSET_ZERO_SUMMARY: begin
                read_value[7:0] = zero_field;
            end
            irq_summary_pkg::OFFSET_EVENT_STATUS: begin
                hit_status          = 1'b1;
                read_value[NCH-1:0] = state.status;
            end
            irq_summary_pkg::OFFSET_EVENT_MASK: begin
                hit_mask            = 1'b1;
                read_value[NCH-1:0] = state.mask;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // byte lanes
    // ------------------------------------------------------------------
    logic [DW-1:0] lane_mask;

    always_comb begin
        lane_mask = irq_summary_pkg::RDATA_RESET;
        for (int b = 0; b < irq_summary_pkg::STROBE_WIDTH; b++) begin
            lane_mask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic           setup_phase;
    logic           write_commit;
    logic [NCH-1:0] rise;
    logic [NCH-1:0] clear_bits;
    logic [NCH-1:0] write_bits;
    logic [NCH-1:0] mask_lanes;

    always_comb begin
        next_state   = state;
        setup_phase  = psel & ~penable;
        // writes land on the single access edge; zero-wait, so pready is high there
        write_commit = psel & penable & pwrite;
        mask_lanes   = lane_mask[NCH-1:0];
        write_bits   = pwdata[NCH-1:0] & mask_lanes;
        rise         = pending & ~state.seen;
        clear_bits   = {NCH{write_commit & hit_status}} & write_bits;

        // read data is captured at the setup edge so it comes from a flop
        if (setup_phase) begin
            next_state.rdata = pwrite ? irq_summary_pkg::RDATA_RESET : read_value;
            next_state.err   = ~mapped;
        end

        // a new pending edge in the clearing cycle survives the clear
        next_state.seen   = pending;
        next_state.status = (state.status & ~clear_bits) | rise;

        if (write_commit & hit_mask) begin
            next_state.mask = (state.mask & ~mask_lanes) | write_bits;
        end
        // summary registers take no write: their bits mirror the channels
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= RESET_STATE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata          = state.rdata;
    assign pready          = 1'b1;
    // err is held from setup; gate so it only shows during the access phase
    assign pslverr         = psel & penable & state.err;
    assign channel_pending = pending;
    assign irq             = |(state.status & state.mask);

endmodule : irq_summary_top

`default_nettype wire

/* shared/irq_summary_pkg.sv */
package irq_summary_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_CHANNELS        = 22;
    localparam int SOURCES_PER_CHANNEL = 8;
    localparam int DATA_WIDTH          = 32;
    localparam int ADDR_WIDTH          = 12;
    localparam int STROBE_WIDTH        = 4;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] OFFSET_LOW_SUMMARY   = 12'h2C0;
    localparam logic [11:0] OFFSET_MID_SUMMARY   = 12'h300;
    localparam logic [11:0] OFFSET_UPPER_SUMMARY = 12'h340;
    localparam logic [11:0] OFFSET_ZERO_SUMMARY  = 12'h380;
    localparam logic [11:0] OFFSET_EVENT_STATUS  = 12'h3E0;
    localparam logic [11:0] OFFSET_EVENT_MASK    = 12'h3E4;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int LOW_FIRST_CHANNEL   = 1;
    localparam int MID_FIRST_CHANNEL   = 9;
    localparam int UPPER_FIRST_CHANNEL = 17;
    localparam int BYTE_FIELD_WIDTH    = 8;
    localparam int UPPER_FIELD_WIDTH   = 5;
    localparam int ZERO_CHANNEL        = 0;
    localparam int ZERO_FIELD_BIT      = 7;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]              SUMMARY_RESET = 8'h00;
    localparam logic [NUM_CHANNELS-1:0] STATUS_RESET  = 22'h000000;
    localparam logic [NUM_CHANNELS-1:0] MASK_RESET    = 22'h000000;
    localparam logic [DATA_WIDTH-1:0]   RDATA_RESET   = 32'h00000000;
    localparam logic                    PENDING_RESET = 1'b0;

endpackage : irq_summary_pkg

/* hw/channel_aggregate.sv */
`timescale 1ns/1ps
`default_nettype none

module channel_aggregate #(
    parameter int SOURCES = irq_summary_pkg::SOURCES_PER_CHANNEL
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [SOURCES-1:0] sources,
    output logic                    pending
);

    typedef struct packed {
        logic pending;
    } agg_state_t;

    agg_state_t state;
    agg_state_t next_state;

    always_comb begin
        next_state         = state;
        // level follows the sources: set while any is high, clear once all drop
        next_state.pending = |sources;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state.pending <= irq_summary_pkg::PENDING_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign pending = state.pending;

endmodule : channel_aggregate

`default_nettype wire

/* dv/irq_summary_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module irq_summary_monitor #(
    parameter int SOURCES = 8
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    input wire logic [22*SOURCES-1:0] channel_sources,
    input wire logic [21:0]           channel_pending,
    input wire logic                  irq
);
    // ------------------------------------------------------------------
    // per-channel source summary
    // ------------------------------------------------------------------
    logic [21:0] any_src;

    always_comb begin
        for (int c = 0; c < 22; c++) begin
            any_src[c] = |channel_sources[c*SOURCES +: SOURCES];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // read data is captured at the setup edge, so compare with pending one edge back
    sequence s_rd(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a ##1 psel && penable;
    endsequence

    property p_pend;
        $past(rst_n) |-> channel_pending == $past(any_src);
    endproperty
    property p_upper;
        s_rd(irq_summary_pkg::OFFSET_UPPER_SUMMARY) |->
            prdata == {27'h0000000, $past(channel_pending[21:17])};
    endproperty
    property p_zero;
        s_rd(irq_summary_pkg::OFFSET_ZERO_SUMMARY) |->
            prdata == {24'h000000, $past(channel_pending[0]), 7'h00};
    endproperty
    property p_low;
        s_rd(irq_summary_pkg::OFFSET_LOW_SUMMARY) |->
            prdata == {24'h000000, $past(channel_pending[8:1])};
    endproperty
    property p_mid;
        s_rd(irq_summary_pkg::OFFSET_MID_SUMMARY) |->
            prdata == {24'h000000, $past(channel_pending[16:9])};
    endproperty
    property p_rst;
        disable iff (1'b0) !rst_n |=> channel_pending == 22'h000000 && !irq && prdata == 32'h0;
    endproperty
    property p_wr;
        psel && penable && pwrite && (paddr == irq_summary_pkg::OFFSET_UPPER_SUMMARY ||
            paddr == irq_summary_pkg::OFFSET_ZERO_SUMMARY) |-> !pslverr;
    endproperty

    a_pend: assert property (p_pend) else $error("pending mismatch");
    a_upper: assert property (p_upper) else $error("upper summary mismatch");
    a_zero: assert property (p_zero) else $error("channel zero summary mismatch");
    a_low: assert property (p_low) else $error("low summary mismatch");
    a_mid: assert property (p_mid) else $error("mid summary mismatch");
    a_rst: assert property (p_rst) else $error("reset value mismatch");
    a_wr: assert property (p_wr) else $error("summary write refused");
endmodule : irq_summary_monitor

bind irq_summary_top irq_summary_monitor #(.SOURCES(SOURCES)) mon (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pslverr(pslverr), .channel_sources(channel_sources), .channel_pending(channel_pending),
    .irq(irq));

`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end

module tb_top;
    logic         clk;
    logic         rst_n;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [11:0]  paddr;
    logic [31:0]  pwdata;
    logic [3:0]   pstrb;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [175:0] src;
    logic [21:0]  pend;
    logic         irq;
    logic [31:0]  q;
    logic         se;
    logic [11:0]  a;
    logic [31:0]  e;
    int           err_total;
    int           cmp_count;

    irq_summary_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .channel_sources(src), .channel_pending(pend),
        .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // bus and stimulus helpers
    // ------------------------------------------------------------------
    task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            err_total++;
            test_done();
        end
        q = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] ad, input logic [31:0] ex, input string nm);
        apb(ad, 1'b0, 32'h0);
        `CHK(nm, ex, q)
    endtask : rd

    task automatic drive(input logic [175:0] v);
        @(posedge clk);
        src <= v;
    endtask : drive

    // lets the edge's updates land before outputs are looked at
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : settle

    initial begin
        err_total = 0;
        cmp_count = 0;
        rst_n   <= 1'b0;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'b0;
        paddr   <= 12'h000;
        pwdata  <= 32'h0;
        pstrb   <= 4'hF;
        src     <= '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(irq_summary_pkg::OFFSET_UPPER_SUMMARY, 32'h0, "upper");
        rd(irq_summary_pkg::OFFSET_ZERO_SUMMARY, 32'h0, "zero");
        $display("test reset done");
        for (int c = 0; c < 22; c++) begin
            a = c == 0 ? irq_summary_pkg::OFFSET_ZERO_SUMMARY : c < 9 ?
                irq_summary_pkg::OFFSET_LOW_SUMMARY : c < 17 ?
                irq_summary_pkg::OFFSET_MID_SUMMARY : irq_summary_pkg::OFFSET_UPPER_SUMMARY;
            e = c == 0 ? 32'h80 : 32'h1 << ((c - 1) % 8);
            drive(176'h1 << (c * 8 + c % 8));
            settle(2);
            rd(a, e, "walk set");
            drive('0);
            settle(2);
            rd(a, 32'h0, "walk clear");
        end
        $display("test channel walk done");
        drive({176{1'b1}});
        settle(2);
        rd(irq_summary_pkg::OFFSET_UPPER_SUMMARY, 32'h1F, "upper all");
        rd(irq_summary_pkg::OFFSET_ZERO_SUMMARY, 32'h80, "zero all");
        drive('0);
        apb(irq_summary_pkg::OFFSET_UPPER_SUMMARY, 1'b1, 32'hFFFFFFFF);
        apb(irq_summary_pkg::OFFSET_ZERO_SUMMARY, 1'b1, 32'hFFFFFFFF);
        rd(irq_summary_pkg::OFFSET_UPPER_SUMMARY, 32'h0, "upper written");
        rd(irq_summary_pkg::OFFSET_ZERO_SUMMARY, 32'h0, "zero written");
        $display("test reserved done");
        apb(irq_summary_pkg::OFFSET_EVENT_STATUS, 1'b1, 32'hFFFFFFFF);
        apb(irq_summary_pkg::OFFSET_EVENT_MASK, 1'b1, 32'h1 << 18);
        rd(irq_summary_pkg::OFFSET_EVENT_STATUS, 32'h0, "status cleared");
        drive(176'h1 << 24);
        settle(3);
        `CHK("irq masked", 1'b0, irq)
        drive(176'h1 << 144);
        settle(3);
        `CHK("irq raised", 1'b1, irq)
        drive('0);
        settle(3);
        `CHK("irq sticky", 1'b1, irq)
        apb(irq_summary_pkg::OFFSET_EVENT_STATUS, 1'b1, 32'h1 << 18);
        settle(1);
        `CHK("irq cleared", 1'b0, irq)
        rd(irq_summary_pkg::OFFSET_EVENT_STATUS, 32'h8, "status left");
        apb(12'h004, 1'b0, 32'h0);
        `CHK("unmapped error", 1'b1, se)
        $display("test interrupt done");
        drive({176{1'b1}});
        settle(2);
        @(posedge clk);
        rst_n <= 1'b0;
        settle(2);
        `CHK("pending in reset", 22'h000000, pend)
        `CHK("irq in reset", 1'b0, irq)
        @(posedge clk);
        rst_n <= 1'b1;
        // sources stayed high through reset, so pending must return one edge after release
        settle(2);
        `CHK("pending after reset", 22'h3FFFFF, pend)
        rd(irq_summary_pkg::OFFSET_ZERO_SUMMARY, 32'h80, "zero after reset");
        $display("test second reset done");
        test_done();
    end
endmodule : tb_top

`default_nettype wire
